// ==== hdl/irqvp_core.sv ====
// Interrupt enable, priority arbitration and vector request core
//
// Local design decision: the AHB-Lite register port.
`default_nettype none
module irqvp_core #(
    parameter int ADDR_DEC_W = 8
) (
    input  wire logic                 CLOCK,        // System clock
    input  wire logic                 NRST,         // Synchronous reset, active low
    input  wire logic                 HSEL,         // AHB slave select
    input  wire logic [31:0]          HADDR,        // AHB address
    input  wire logic [1:0]           HTRANS,       // AHB transfer type
    input  wire logic                 HWRITE,       // AHB write
    input  wire logic [2:0]           HSIZE,        // AHB size
    input  wire logic [31:0]          HWDATA,       // AHB write data
    input  wire logic                 HREADY,       // AHB bus ready
    output logic                      HREADYOUT,    // AHB slave ready
    output logic [31:0]               HRDATA,       // AHB read data
    output logic                      HRESP,        // AHB response
    input  wire irqvp_pkg::irqvp_pend_s PEND,       // Peripheral pending flags
    input  wire logic [16:7]          UPPER_ENABLE, // Enables of sources 7..16
    input  wire logic [16:7]          UPPER_LEVEL,  // Levels of sources 7..16
    input  wire logic [1:0]           EXT_EDGE_MODE,// External inputs edge mode
    output irqvp_pkg::irqvp_req_s     REQ,          // Vector request to the core
    input  wire logic                 VEC_ACK,      // Core takes the vector
    input  wire logic                 SVC_RETURN,   // Core returns from service
    output logic [16:0]               CLEAR_PEND    // Flag clear pulse
);
    import irqvp_pkg::*;

    initial begin
        if (ADDR_DEC_W < 8 || ADDR_DEC_W > 32) begin
            $error("ADDR_DEC_W must lie between 8 and 32");
        end
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [4:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [15:0] vector_of(input logic [4:0] order);
        return VECTOR_BASE + (16'(order) << 3);
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [7:0]  enable_r;
    logic [7:0]  enable_nxt;
    logic [6:0]  level_r;
    logic [6:0]  level_nxt;
    logic [31:0] rdata_r;
    logic        addr_ph;
    logic [7:0]  rd_addr;
    irqvp_svc_e  svc_r;
    irqvp_svc_e  svc_nxt;

    assign addr_ph   = HSEL && HREADY && HTRANS[1];
    assign rd_addr   = HADDR[7:0];
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_r;

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (HREADY) begin
            wr_pend_r <= addr_ph && HWRITE && (HADDR[1:0] == 2'h0) &&
                         ((HADDR & ((32'h1 << ADDR_DEC_W) - 32'h1) & 32'hFFFF_FF00)
                          == 32'h0000_0000);
            wr_addr_r <= HADDR[7:0];
        end
    end

    always_comb begin
        enable_nxt = enable_r;
        level_nxt  = level_r;
        if (wr_pend_r && wr_addr_r == IRQ_ENABLE_MASK_OFS) begin
            enable_nxt = HWDATA[7:0];
        end
        if (wr_pend_r && wr_addr_r == IRQ_LEVEL_SELECT_OFS) begin
            level_nxt = HWDATA[6:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            enable_r <= IRQ_ENABLE_MASK_RST;
            level_r  <= IRQ_LEVEL_SELECT_RST[6:0];
        end else begin
            enable_r <= enable_nxt;
            level_r  <= level_nxt;
        end
    end

    // Read data is built in the address phase from the next values
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            rdata_r <= 32'h0000_0000;
        end else if (addr_ph && !HWRITE) begin
            unique case (rd_addr)
                IRQ_ENABLE_MASK_OFS:  rdata_r <= {24'h000000, enable_nxt};
                IRQ_LEVEL_SELECT_OFS: rdata_r <= {24'h000000, 1'b1, level_nxt};
                IRQ_SERVICE_STAT_OFS: rdata_r <= {8'h00, REQ.vector, 6'h00, svc_nxt};
                default:              rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Enables and levels per source
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] src_hi;
    logic [NUM_SRC-1:0] active;

    assign pend = {PEND.upper_pend, PEND.sync_serial_pend,
                   PEND.timer2_high_overflow_flag | PEND.timer2_low_overflow_flag,
                   PEND.async_port0_pend, PEND.timer1_overflow_flag,
                   PEND.ext_irq_input_b_pend, PEND.timer0_overflow_flag,
                   PEND.ext_irq_input_a_pend};

    assign src_en[SRC_SYNC_SER] = enable_r[SRC_SYNC_SER];
    assign src_en[SRC_TIMER2]   = enable_r[SRC_TIMER2];
    assign src_en[SRC_ASYNC0]   = enable_r[SRC_ASYNC0];
    assign src_en[SRC_TIMER1]   = enable_r[SRC_TIMER1];
    assign src_en[SRC_EXT1]     = enable_r[SRC_EXT1];
    assign src_en[SRC_TIMER0]   = enable_r[SRC_TIMER0];
    assign src_en[SRC_EXT0]     = enable_r[SRC_EXT0];
    assign src_en[16:7]         = UPPER_ENABLE;

    assign src_hi[SRC_SYNC_SER] = level_r[SRC_SYNC_SER];
    assign src_hi[SRC_TIMER2]   = level_r[SRC_TIMER2];
    assign src_hi[SRC_ASYNC0]   = level_r[SRC_ASYNC0];
    assign src_hi[SRC_TIMER1]   = level_r[SRC_TIMER1];
    assign src_hi[SRC_EXT1]     = level_r[SRC_EXT1];
    assign src_hi[SRC_TIMER0]   = level_r[SRC_TIMER0];
    assign src_hi[SRC_EXT0]     = level_r[SRC_EXT0];
    assign src_hi[16:7]         = UPPER_LEVEL;

    // Global enable overrides every individual mask
    assign active = pend & src_en & {NUM_SRC{enable_r[GLOBAL_EN_BIT]}};

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] act_hi;
    logic [NUM_SRC-1:0] act_lo;
    logic               high_ok;
    logic               low_ok;
    logic               req_valid;
    logic               req_high;
    logic [4:0]         req_order;

    assign act_hi  = active & src_hi;
    assign act_lo  = active & ~src_hi;
    // A high routine blocks everything; a low one blocks only low
    assign high_ok = |act_hi && (svc_r == SVC_NONE || svc_r == SVC_LOW);
    assign low_ok  = |act_lo && svc_r == SVC_NONE;

    always_comb begin
        req_valid = high_ok || low_ok;
        req_high  = high_ok;
        req_order = high_ok ? first_set(act_hi) : first_set(act_lo);
    end

    // Decoded afresh on every clock
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            REQ <= '{valid: 1'b0, high_level: 1'b1, order: 5'h00,
                     vector: RESET_VECTOR};
        end else begin
            REQ.valid      <= req_valid && !VEC_ACK;
            REQ.high_level <= req_high;
            REQ.order      <= req_order;
            REQ.vector     <= vector_of(req_order);
        end
    end

    // ------------------------------------------------------------
    // Service nesting
    // ------------------------------------------------------------
    logic ack_ok;

    assign ack_ok = VEC_ACK && REQ.valid;

    always_comb begin
        svc_nxt = svc_r;
        if (ack_ok) begin
            svc_nxt = REQ.high_level ? ((svc_r == SVC_LOW) ? SVC_BOTH : SVC_HIGH)
                                     : SVC_LOW;
        end else if (SVC_RETURN) begin
            unique case (svc_r)
                SVC_NONE: svc_nxt = SVC_NONE;
                SVC_LOW:  svc_nxt = SVC_NONE;
                SVC_HIGH: svc_nxt = SVC_NONE;
                SVC_BOTH: svc_nxt = SVC_LOW;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            svc_r <= SVC_NONE;
        end else begin
            svc_r <= svc_nxt;
        end
    end

    // Only the flags in the clear mask are wiped; the rest is software's job
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            CLEAR_PEND <= 17'h00000;
        end else begin
            CLEAR_PEND <= '0;
            if (ack_ok && HW_CLEAR_MASK[REQ.order] &&
                !(REQ.order == 5'(SRC_EXT0) && !EXT_EDGE_MODE[0]) &&
                !(REQ.order == 5'(SRC_EXT1) && !EXT_EDGE_MODE[1])) begin
                CLEAR_PEND[REQ.order] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] lower_mask;

    always_comb begin
        lower_mask = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (5'(i) < REQ.order) begin
                lower_mask[i] = 1'b1;
            end
        end
    end

    sequence s_high_waits;
        |act_hi && svc_r == SVC_LOW && !VEC_ACK;
    endsequence

    sequence s_high_taken;
        REQ.valid && REQ.high_level;
    endsequence

    a_global_gate: assert property (@(posedge CLOCK) disable iff (!NRST)
        !enable_r[GLOBAL_EN_BIT] |=> !REQ.valid)
        else $error("request raised with global enable clear");

    a_vector_step: assert property (@(posedge CLOCK) disable iff (!NRST)
        REQ.valid |-> REQ.vector == VECTOR_BASE + 16'(REQ.order) * 16'h0008
                      && REQ.vector <= VECTOR_LAST)
        else $error("vector does not match source order");

    a_reset_vector: assert property (@(posedge CLOCK)
        !NRST |=> REQ.vector == RESET_VECTOR && !REQ.valid)
        else $error("reset does not point at the reset vector");

    a_order_tie: assert property (@(posedge CLOCK) disable iff (!NRST)
        REQ.valid && $stable(active) && $stable(src_hi) && $stable(svc_r) |->
            ((REQ.high_level ? $past(act_hi) : $past(act_lo)) & lower_mask) == '0)
        else $error("lower order source of same level was skipped");

    a_high_preempt: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_high_waits |=> s_high_taken)
        else $error("high request did not preempt low service");

    a_high_locked: assert property (@(posedge CLOCK) disable iff (!NRST)
        svc_r == SVC_HIGH && $past(svc_r) == SVC_HIGH |-> !REQ.valid)
        else $error("request raised during high service");

    a_level_fixed: assert property (@(posedge CLOCK) disable iff (!NRST)
        addr_ph && !HWRITE && rd_addr == IRQ_LEVEL_SELECT_OFS |=>
            HRDATA[LEVEL_FIXED_BIT])
        else $error("level register bit 7 read as zero");

    a_mask_gate: assert property (@(posedge CLOCK) disable iff (!NRST)
        REQ.valid && $stable(enable_r) |->
            ($past(src_en & pend) & (17'h00001 << REQ.order)) != '0)
        else $error("request from a masked or idle source");

    a_hw_clear: assert property (@(posedge CLOCK) disable iff (!NRST)
        ack_ok && REQ.order > 5'(SRC_TIMER1) |=> CLEAR_PEND == '0)
        else $error("core cleared a software owned flag");

    a_sampled: assert property (@(posedge CLOCK) disable iff (!NRST)
        req_valid && !VEC_ACK |=> REQ.valid ##0 REQ.order == $past(req_order))
        else $error("pending request not decoded in one cycle");

endmodule
`default_nettype wire

// ==== hdl/irqvp_pkg.sv ====
// Package for the interrupt enable, priority and vector core
`default_nettype none
package irqvp_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the bus)
    // ------------------------------------------------------------
    localparam logic [7:0] IRQ_ENABLE_MASK_OFS  = 8'hA8;
    localparam logic [7:0] IRQ_LEVEL_SELECT_OFS = 8'hB8;
    localparam logic [7:0] IRQ_SERVICE_STAT_OFS = 8'hC0;

    localparam logic [7:0] IRQ_ENABLE_MASK_RST  = 8'h00;
    localparam logic [7:0] IRQ_LEVEL_SELECT_RST = 8'h80;

    // Field positions in the enable and level registers
    localparam int GLOBAL_EN_BIT   = 7;
    localparam int LEVEL_FIXED_BIT = 7;
    localparam int SRC_EXT0        = 0;
    localparam int SRC_TIMER0      = 1;
    localparam int SRC_EXT1        = 2;
    localparam int SRC_TIMER1      = 3;
    localparam int SRC_ASYNC0      = 4;
    localparam int SRC_TIMER2      = 5;
    localparam int SRC_SYNC_SER    = 6;
    localparam int NUM_LOCAL_SRC   = 7;
    localparam int NUM_SRC         = 17;

    // Vector table
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;
    localparam logic [15:0] VECTOR_BASE   = 16'h0003;
    localparam logic [15:0] VECTOR_STRIDE = 16'h0008;
    localparam logic [15:0] VECTOR_LAST   = 16'h0083;

    // Sources whose pending flag the core clears when it vectors (external inputs only in edge mode)
    localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 17'h0000F;

    // Service nesting state
    typedef enum logic [1:0] {
        SVC_NONE,
        SVC_LOW,
        SVC_HIGH,
        SVC_BOTH
    } irqvp_svc_e;

    // Pending flags coming from the peripherals
    typedef struct packed {
        logic [NUM_SRC-1:7] upper_pend;
        logic               sync_serial_pend;
        logic               timer2_high_overflow_flag;
        logic               timer2_low_overflow_flag;
        logic               async_port0_pend;
        logic               timer1_overflow_flag;
        logic               ext_irq_input_b_pend;
        logic               timer0_overflow_flag;
        logic               ext_irq_input_a_pend;
    } irqvp_pend_s;

    // Request to the processor core
    typedef struct packed {
        logic        valid;
        logic        high_level;
        logic [4:0]  order;
        logic [15:0] vector;
    } irqvp_req_s;

endpackage
`default_nettype wire

// ==== test/irqvp_cpu_model.sv ====
// Processor-side model that takes interrupt vectors from the core
`default_nettype none
module irqvp_cpu_model (
    input  wire logic                  clk,     // System clock
    input  wire logic                  nrst,    // Synchronous reset, active low
    input  wire irqvp_pkg::irqvp_req_s req,     // Request from the core
    input  wire logic                  slow,    // Take vectors late
    output logic                       vec_ack  // One-cycle vector take
);
    timeunit 1ns;
    timeprecision 1ns;
    import irqvp_pkg::*;

    logic [1:0] wait_r;

    // ------------------------------------------------------------
    // Vector take
    // ------------------------------------------------------------
    // Rest one cycle after a take so a request that is just dropping is not taken twice
    always_ff @(posedge clk) begin
        if (!nrst) begin
            vec_ack <= 1'b0;
            wait_r  <= 2'd0;
        end else if (vec_ack) begin
            vec_ack <= 1'b0;
            wait_r  <= 2'd0;
        end else if (req.valid && (!slow || wait_r == 2'd3)) begin
            vec_ack <= 1'b1;
        end else if (req.valid) begin
            wait_r <= wait_r + 2'd1;
        end
    end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the interrupt enable, priority and vector core
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import irqvp_pkg::*;

    logic CLOCK, NRST, HSEL, HWRITE, HREADYOUT, HRESP, VEC_ACK, SVC_RETURN, slow, rd_dp;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0]  HTRANS, EXT_EDGE_MODE;
    logic [2:0]  HSIZE;
    logic [16:7] UPPER_ENABLE, UPPER_LEVEL;
    irqvp_pend_s pend;
    irqvp_req_s  REQ;
    int          errors, total_checks, n_vec, j, o, t, dummy;
    logic [7:0]  lv;
    logic [17:0] pv;
    logic [16:0] act, hi, clr_exp, clr_seen;
    logic        clr_due;
    logic [31:0] rd_q[$];
    logic [15:0] vq[$];

    irqvp_core dut_u (.CLOCK(CLOCK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
        .PEND(pend), .UPPER_ENABLE(UPPER_ENABLE), .UPPER_LEVEL(UPPER_LEVEL),
        .EXT_EDGE_MODE(EXT_EDGE_MODE), .REQ(REQ), .VEC_ACK(VEC_ACK),
        .SVC_RETURN(SVC_RETURN), .CLEAR_PEND(clr_seen));
    irqvp_cpu_model cpu_u (.clk(CLOCK), .nrst(NRST), .req(REQ), .slow(slow),
        .vec_ack(VEC_ACK));

    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rdy();
        int n;
        n = 0;
        do begin @(posedge CLOCK); n++; end while (HREADYOUT !== 1'b1 && n < 50);
        if (n >= 50) begin errors++; close_out(); end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1; HTRANS <= 2'b10; HADDR <= {24'h0, a}; HWRITE <= w;
        rdy();
        HSEL <= 1'b0; HTRANS <= 2'b00; HWDATA <= d; rd_dp <= !w;
        rdy();
        rd_dp <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic wv();
        int n;
        n = 0;
        do begin @(posedge CLOCK); n++; end
        while (!(VEC_ACK === 1'b1 && REQ.valid === 1'b1) && n < 40);
        if (n >= 40) begin errors++; close_out(); end
    endtask

    task automatic quiet(); // No request may appear
        repeat (4) @(posedge CLOCK);
        chk("req_valid", 32'h0, {31'h0, REQ.valid});
    endtask

    task automatic ret();
        SVC_RETURN <= 1'b1; @(posedge CLOCK);
        SVC_RETURN <= 1'b0; @(posedge CLOCK);
    endtask

    function automatic int lowest(input logic [16:0] v);
        for (int k = 0; k < 17; k++) if (v[k]) return k;
        return 0;
    endfunction

    // ------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (rd_dp && HREADYOUT === 1'b1)
            chk("hrdata", rd_q.size() ? rd_q.pop_front() : 32'hFFFF_FFFF, HRDATA);
        if (clr_due === 1'b1)
            chk("clear_pend", {15'h0, clr_exp}, {15'h0, clr_seen});
        clr_due = 1'b0;
        if (VEC_ACK && REQ.valid === 1'b1) begin
            // Timers 0/1 always; external inputs only in edge mode
            clr_exp = 17'h00000;
            if (REQ.order < 5'd4 && (REQ.order[0] || EXT_EDGE_MODE[REQ.order[1]]))
                clr_exp[REQ.order] = 1'b1;
            clr_due = 1'b1;
            chk("vector", vq.size() ? {16'h0, vq.pop_front()} : 32'hFFFF_FFFF,
                {16'h0, REQ.vector});
            n_vec++;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        NRST = 0; HSEL = 0; HADDR = 0; HTRANS = 0; HWRITE = 0; HSIZE = 3'b010;
        HWDATA = 0; pend = '0; UPPER_ENABLE = 0; UPPER_LEVEL = 0; EXT_EDGE_MODE = 0;
        SVC_RETURN = 0; slow = 0; rd_dp = 0; errors = 0; total_checks = 0; n_vec = 0;
        clr_due = 0; clr_exp = 0;
        dummy = $urandom(69869);
        repeat (20) @(posedge CLOCK);
        NRST <= 1'b1;
        @(posedge CLOCK);
        rd(8'hA8, 32'h00); rd(8'hB8, 32'h80);
        bus(1'b1, 8'hB8, 32'h00); rd(8'hB8, 32'h80);
        bus(1'b1, 8'hB8, 32'hFF); rd(8'hB8, 32'hFF); rd(8'h10, 32'h0);
        bus(1'b1, 8'hA8, 32'h1A5); rd(8'hA8, 32'hA5);
        $display("test registers done");
        bus(1'b1, 8'hB8, 32'h0); bus(1'b1, 8'hA8, 32'h7F);
        pend <= 18'h000FF; quiet();
        pend <= '0;
        for (j = 0; j < 8; j++) begin
            o = j - (j > 5);
            bus(1'b1, 8'hA8, 32'hFF ^ (32'h1 << o));
            pend <= '0; pend[j] <= 1'b1; quiet();
            vq.push_back(16'h3 + 16'h8 * o[15:0]);
            bus(1'b1, 8'hA8, 32'h80 | (32'h1 << o)); wv();
            pend <= '0; ret();
        end
        $display("test masks done");
        bus(1'b1, 8'hA8, 32'hFF);
        for (t = 0; t < 30; t++) begin
            lv = 8'($urandom); UPPER_ENABLE <= 10'($urandom); UPPER_LEVEL <= 10'($urandom);
            EXT_EDGE_MODE <= 2'($urandom); slow <= 1'($urandom);
            bus(1'b1, 8'hB8, {24'h0, lv});
            pv = 18'($urandom) & 18'($urandom);
            act = {pv[17:8], pv[7], pv[6] | pv[5], pv[4:0]} & {UPPER_ENABLE, 7'h7F};
            if (act == 0) begin pv[0] = 1'b1; act[0] = 1'b1; end
            hi = act & {UPPER_LEVEL, lv[6:0]};
            vq.push_back(16'h3 + 16'h8 * 16'(lowest(hi != 0 ? hi : act)));
            pend <= pv; wv();
            pend <= '0; ret();
        end
        $display("test arbitration done");
        slow <= 1'b0; EXT_EDGE_MODE <= 2'b00; UPPER_ENABLE <= '0;
        bus(1'b1, 8'hB8, 32'h12);
        vq.push_back(16'h03); pend <= 18'h00001; wv();
        vq.push_back(16'h0B); pend <= 18'h00003; wv();
        pend <= 18'h00013; quiet();
        vq.push_back(16'h23); pend <= 18'h00011; ret(); wv();
        pend <= '0; ret(); ret(); quiet();
        $display("test preemption done");
        close_out();
    end
endmodule
`default_nettype wire
